// ### esbs_lamp.sv
// esbs_lamp: blink-code sequencer for the bicolour status lamp.
// assumes pattern input steady for several phases; restarts on change.
module esbs_lamp
    import esbs_pkg::*;
#(
    parameter int PHASE_CYC = ESBS_PHASE_CYC
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  esbs_pat_t       pattern,
    output esbs_lamp_t      lamp
);
    logic [31:0] tick_q;
    logic [1:0]  step_q;
    esbs_pat_t   pat_q;
    esbs_lamp_t  lamp_d;
    esbs_lamp_t  lamp_q;
    wire         tick_end = (tick_q == 32'(PHASE_CYC - 1));

    // phase counter and step of the four-step cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= '0;
            step_q <= '0;
            pat_q  <= ESBS_PAT_OK;
            lamp_q <= ESBS_LAMP_OFF;
        end else if (ce) begin
            pat_q  <= pattern;
            lamp_q <= lamp_d;
            if (pattern != pat_q || tick_end) tick_q <= '0;
            else tick_q <= tick_q + 32'd1;
            if (pattern != pat_q) step_q <= '0;
            else if (tick_end) step_q <= step_q + 2'd1;
        end
    end

    // colour per step; each code fills four phases
    always_comb begin
        unique case (pat_q)
            ESBS_PAT_OK:    lamp_d = ESBS_LAMP_GREEN; // R9
            ESBS_PAT_LOWMP: lamp_d = ESBS_LAMP_RED; // R9
            ESBS_PAT_LOW24: lamp_d = step_q[1] ? ESBS_LAMP_RED
                                               : ESBS_LAMP_GREEN; // R9
            ESBS_PAT_REGEN: lamp_d = (step_q == 2'd0) ? ESBS_LAMP_GREEN
                                                      : ESBS_LAMP_RED; // R9
            ESBS_PAT_OPEN:  lamp_d = step_q[0] ? ESBS_LAMP_RED
                                               : ESBS_LAMP_GREEN; // R9
            // green flash with dark gaps: distinct from solid green
            ESBS_PAT_WAIT:  lamp_d = step_q[0] ? ESBS_LAMP_OFF
                                               : ESBS_LAMP_GREEN; // R2
            default:        lamp_d = ESBS_LAMP_RED;
        endcase
    end

    assign lamp = lamp_q;
endmodule

// ### esbs_panel.sv
// esbs_panel: panel stop loops, reset contact and drive brake lines.
// assumes bench commands change just after pclk rises.
module esbs_panel #(
    parameter int PRESS_CYC = 3
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       want_int,
    input  wire logic       want_ext,
    input  wire logic       press,
    input  wire logic [1:0] want_brk,
    output logic            internal_stop_loop,
    output logic            external_stop_loop,
    output logic            reset_contact,
    output logic      [1:0] brk_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] press_q;
    // contacts move one edge after a command, like a real panel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_stop_loop <= 1'b0;
            external_stop_loop <= 1'b0;
            brk_req            <= 2'b00;
            press_q            <= 4'h0;
        end else begin
            internal_stop_loop <= want_int;
            external_stop_loop <= want_ext;
            brk_req            <= want_brk;
            press_q <= press ? 4'(PRESS_CYC) :
                (press_q == 4'h0 ? 4'h0 : press_q - 4'h1);
        end
    end
    // closure lasts while press is high and for PRESS_CYC cycles after it drops
    assign reset_contact = (press_q != 4'h0);
endmodule

// ### esbs_pkg.sv
// esbs_pkg: shared constants for the stop and brake supervisor.
// assumes one 125 MHz clock (pclk) and an apb register slave.
package esbs_pkg;
    // register byte offsets
    localparam logic [11:0] ESBS_OFF_CFG    = 12'h000;
    localparam logic [11:0] ESBS_OFF_STATUS = 12'h004;
    localparam logic [11:0] ESBS_OFF_IRQ_ST = 12'h008;
    localparam logic [11:0] ESBS_OFF_IRQ_EN = 12'h00c;
    localparam logic [11:0] ESBS_OFF_IRQ_CL = 12'h010;
    localparam logic [11:0] ESBS_OFF_MON    = 12'h014;
    // config switch bit positions (switch n at bit n-1)
    localparam int ESBS_SW_RESET = 0;
    localparam int ESBS_SW_BPOL  = 1;
    localparam int ESBS_SW_LOGIC = 2;
    localparam int ESBS_SW_RELAY = 3;
    localparam int ESBS_SW_INT   = 4;
    localparam int ESBS_SW_EXT   = 5;
    localparam int ESBS_SW_UV    = 6;
    // interrupt bit positions
    localparam int ESBS_IRQ_STOP  = 0;
    localparam int ESBS_IRQ_ARMED = 1;
    localparam int ESBS_IRQ_UV    = 2;
    localparam int ESBS_IRQ_W     = 3;
    // reset values
    localparam logic [7:0] ESBS_CFG_RST = 8'h70;
    // lamp timing: one blink phase in ns and cycles
    localparam int ESBS_CLK_NS      = 8;
    localparam int ESBS_PHASE_NS    = 250000000;
    localparam int ESBS_PHASE_CYC   = ESBS_PHASE_NS / ESBS_CLK_NS;
    localparam int ESBS_STEPS       = 4;
    // lamp colour codes
    typedef enum logic [1:0] {
        ESBS_LAMP_OFF   = 2'b00,
        ESBS_LAMP_GREEN = 2'b01,
        ESBS_LAMP_RED   = 2'b10
    } esbs_lamp_t;
    // lamp pattern selectors
    typedef enum logic [5:0] {
        ESBS_PAT_OK    = 6'b000001,
        ESBS_PAT_WAIT  = 6'b000010,
        ESBS_PAT_LOWMP = 6'b000100,
        ESBS_PAT_LOW24 = 6'b001000,
        ESBS_PAT_REGEN = 6'b010000,
        ESBS_PAT_OPEN  = 6'b100000
    } esbs_pat_t;
endpackage

// ### esbs_top.sv
// esbs_top: emergency stop, motor power enable and brake supervisor.
// assumes all pin inputs are synchronous to pclk; apb register access.
// Operation
// (R1) switch 1: power waits for reset contact
// (R2) waiting-for-reset shows distinct lamp code
// (R3) switch 2 sets brake request polarity
// (R4) switch 3: logic output follows power
// (R5) switch 4: relay opens during stop
// (R6) switch 5: internal loop must be closed
// (R7) switch 6: external loop must be closed
// (R8) switch 7 enables under-voltage reporting
// (R9) lamp codes: green, red, blink patterns
// (R10) any open enabled loop blocks power
module esbs_top
    import esbs_pkg::*;
#(
    parameter int PHASE_CYC = ESBS_PHASE_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        internal_stop_loop,
    input  wire logic        external_stop_loop,
    input  wire logic        reset_contact,
    input  wire logic        low_motor_volt,
    input  wire logic        low_logic_volt,
    input  wire logic        regen_locked,
    input  wire logic        brake_one_request,
    input  wire logic        brake_two_request,
    output logic             brake_one_output,
    output logic             brake_two_output,
    output logic             motor_power_en,
    output logic             stop_logic_output,
    output logic             relay_closed,
    output esbs_lamp_t       lamp,
    output logic             irq
);
    logic [7:0]          cfg_q;   // config_switch_bank image
    logic                power_q;
    logic                armed_q;  // loops closed, awaiting reset
    logic                b1_q;
    logic                b2_q;
    logic                logic_q;
    logic                relay_q;
    logic                stop_prev_q;
    logic                arm_prev_q;
    logic                uv_prev_q;
    logic [ESBS_IRQ_W-1:0] ist_q;
    logic [ESBS_IRQ_W-1:0] ien_q;
    logic [31:0]         rdata_q;

    // stop decision: an enabled loop that is open is a stop event
    wire int_open   = cfg_q[ESBS_SW_INT] && !internal_stop_loop; // R6
    wire ext_open   = cfg_q[ESBS_SW_EXT] && !external_stop_loop; // R7
    wire stop_act   = int_open || ext_open; // R10
    wire need_reset = cfg_q[ESBS_SW_RESET];
    wire uv_on      = cfg_q[ESBS_SW_UV];
    wire low_mp     = uv_on && low_motor_volt; // R8
    wire low_24     = uv_on && low_logic_volt; // R8
    wire uv_any     = low_mp || low_24;
    // brake polarity: switch on means high request is active
    wire b1_d = cfg_q[ESBS_SW_BPOL] ? brake_one_request
                                    : !brake_one_request; // R3
    wire b2_d = cfg_q[ESBS_SW_BPOL] ? brake_two_request
                                    : !brake_two_request; // R3

    // apb decode; zero wait states, unmapped offsets error
    wire acc      = psel && penable;
    wire wr       = acc && pwrite;
    wire hit_cfg  = (paddr == ESBS_OFF_CFG);
    wire hit_stat = (paddr == ESBS_OFF_STATUS);
    wire hit_ist  = (paddr == ESBS_OFF_IRQ_ST);
    wire hit_ien  = (paddr == ESBS_OFF_IRQ_EN);
    wire hit_icl  = (paddr == ESBS_OFF_IRQ_CL);
    wire hit_mon  = (paddr == ESBS_OFF_MON);
    wire hit_any  = hit_cfg | hit_stat | hit_ist | hit_ien | hit_icl
                  | hit_mon;
    wire [31:0] stat_word = {25'h0, armed_q, regen_locked, low_24,
                             low_mp, ext_open, int_open, power_q};
    wire [31:0] mon_word  = {24'h0, relay_q, logic_q, b2_q, b1_q,
                             brake_two_request, brake_one_request,
                             external_stop_loop, internal_stop_loop};
    wire [31:0] rd_mux =
        hit_cfg  ? {24'h0, cfg_q} :
        hit_stat ? stat_word :
        hit_ist  ? {29'h0, ist_q} :
        hit_ien  ? {29'h0, ien_q} :
        hit_mon  ? mon_word : 32'h0000_0000;

    // interrupt events: rising edges of stop, armed and under-voltage
    wire [ESBS_IRQ_W-1:0] ev = {uv_any && !uv_prev_q,
                                armed_q && !arm_prev_q,
                                stop_act && !stop_prev_q};
    wire [ESBS_IRQ_W-1:0] clr = (wr && hit_icl) ? pwdata[ESBS_IRQ_W-1:0]
                                                : '0;

    // register file; the clear loses to a same-cycle event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q   <= ESBS_CFG_RST;
            ien_q   <= '0;
            ist_q   <= '0;
            rdata_q <= '0;
        end else if (ce) begin
            if (wr && hit_cfg) cfg_q <= pwdata[7:0];
            if (wr && hit_ien) ien_q <= pwdata[ESBS_IRQ_W-1:0];
            ist_q <= (ist_q & ~clr) | ev;
            if (psel && !penable && !pwrite) rdata_q <= rd_mux;
        end
    end

    // power sequencing and edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_q     <= 1'b0;
            armed_q     <= 1'b0;
            stop_prev_q <= 1'b0;
            arm_prev_q  <= 1'b0;
            uv_prev_q   <= 1'b0;
        end else if (ce) begin
            stop_prev_q <= stop_act;
            arm_prev_q  <= armed_q;
            uv_prev_q   <= uv_any;
            if (stop_act) begin
                power_q <= 1'b0; // R10
                armed_q <= 1'b0;
            end else if (!power_q && !need_reset) begin
                power_q <= 1'b1;
                armed_q <= 1'b0;
            end else if (!power_q && reset_contact) begin
                power_q <= 1'b1; // R1
                armed_q <= 1'b0;
            end else if (!power_q) begin
                armed_q <= 1'b1; // R1
            end else begin
                armed_q <= 1'b0;
            end
        end
    end

    // registered pin outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b1_q    <= 1'b0;
            b2_q    <= 1'b0;
            logic_q <= 1'b0;
            relay_q <= 1'b0;
        end else if (ce) begin
            b1_q    <= b1_d;
            b2_q    <= b2_d;
            logic_q <= cfg_q[ESBS_SW_LOGIC] && power_q; // R4
            // relay stays closed when not tied to stop state
            relay_q <= !(cfg_q[ESBS_SW_RELAY] && stop_act); // R5
        end
    end

    // lamp priority: open loop, waiting, supplies, regen, ok
    wire esbs_pat_t pat =
        stop_act     ? ESBS_PAT_OPEN :
        armed_q      ? ESBS_PAT_WAIT :
        low_mp       ? ESBS_PAT_LOWMP :
        low_24       ? ESBS_PAT_LOW24 :
        regen_locked ? ESBS_PAT_REGEN : ESBS_PAT_OK; // R9

    esbs_lamp #(
        .PHASE_CYC (PHASE_CYC)
    ) u_lamp (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .pattern (pat),
        .lamp    (lamp)
    );

    assign prdata            = rdata_q;
    assign pready            = 1'b1;
    assign pslverr           = acc && !hit_any;
    assign irq               = |(ist_q & ien_q);
    assign brake_one_output  = b1_q;
    assign brake_two_output  = b2_q;
    assign motor_power_en    = power_q;
    assign stop_logic_output = logic_q;
    assign relay_closed      = relay_q;

    // checks
    property p_loop_int;
        @(posedge pclk) disable iff (!presetn)
        (ce && cfg_q[ESBS_SW_INT] && !internal_stop_loop)
            |=> !motor_power_en;
    endproperty
    a_loop_int: assert property (p_loop_int) // R6
        else $error("power on with internal loop open");
    property p_loop_ext;
        @(posedge pclk) disable iff (!presetn)
        (ce && cfg_q[ESBS_SW_EXT] && !external_stop_loop)
            |=> !motor_power_en;
    endproperty
    a_loop_ext: assert property (p_loop_ext) // R7
        else $error("power on with external loop open");
    property p_need_reset;
        @(posedge pclk) disable iff (!presetn)
        (ce && need_reset && !power_q && !reset_contact)
            |=> !motor_power_en;
    endproperty
    a_need_reset: assert property (p_need_reset) // R1
        else $error("power rose without reset contact");
    property p_wait_lamp;
        @(posedge pclk) disable iff (!presetn)
        (ce && armed_q && !stop_act) [*2] |=> lamp != ESBS_LAMP_RED;
    endproperty
    a_wait_lamp: assert property (p_wait_lamp) // R2
        else $error("waiting state lacks its lamp code");
    property p_brake;
        @(posedge pclk) disable iff (!presetn)
        ce |=> brake_one_output == ($past(cfg_q[ESBS_SW_BPOL]) ~^
                                    $past(brake_one_request));
    endproperty
    a_brake: assert property (p_brake) // R3
        else $error("brake one polarity wrong");
    property p_logic_out;
        @(posedge pclk) disable iff (!presetn)
        ce && !cfg_q[ESBS_SW_LOGIC] |=> !stop_logic_output;
    endproperty
    a_logic_out: assert property (p_logic_out) // R4
        else $error("logic output true while disabled");
    property p_relay;
        @(posedge pclk) disable iff (!presetn)
        ce && cfg_q[ESBS_SW_RELAY] && stop_act |=> !relay_closed;
    endproperty
    a_relay: assert property (p_relay) // R5
        else $error("relay closed during stop");
    property p_uv_off;
        @(posedge pclk) disable iff (!presetn)
        ce && !cfg_q[ESBS_SW_UV] && !ist_q[ESBS_IRQ_UV]
            |=> !ist_q[ESBS_IRQ_UV];
    endproperty
    a_uv_off: assert property (p_uv_off) // R8
        else $error("under-voltage reported while off");
    property p_lamp_ok;
        @(posedge pclk) disable iff (!presetn)
        (ce && pat == ESBS_PAT_OK) [*3] |=> lamp == ESBS_LAMP_GREEN;
    endproperty
    a_lamp_ok: assert property (p_lamp_ok) // R9
        else $error("lamp not green with no error");
    property p_stop_power;
        @(posedge pclk) disable iff (!presetn)
        ce && stop_act |=> !motor_power_en ##1 1;
    endproperty
    a_stop_power: assert property (p_stop_power) // R10
        else $error("power on during stop event");
    // per-switch pin behaviour, sticky event and freeze paths
    property p_brake_two;
        @(posedge pclk) disable iff (!presetn)
        ce |=> brake_two_output == ($past(cfg_q[ESBS_SW_BPOL]) ~^
                                    $past(brake_two_request));
    endproperty
    a_brake_two: assert property (p_brake_two) // R3
        else $error("brake two polarity wrong");
    property p_logic_follow;
        @(posedge pclk) disable iff (!presetn)
        ce && cfg_q[ESBS_SW_LOGIC]
            |=> stop_logic_output == $past(motor_power_en);
    endproperty
    a_logic_follow: assert property (p_logic_follow) // R4
        else $error("logic output not following power");
    property p_relay_free;
        @(posedge pclk) disable iff (!presetn)
        ce && !cfg_q[ESBS_SW_RELAY]
            |=> relay_closed;
    endproperty
    a_relay_free: assert property (p_relay_free) // R5
        else $error("relay opened while not tied to stop");
    // set must win over a same-cycle clear
    property p_uv_sticky;
        @(posedge pclk) disable iff (!presetn)
        ce && cfg_q[ESBS_SW_UV] && low_motor_volt && !uv_prev_q
            |=> ist_q[ESBS_IRQ_UV];
    endproperty
    a_uv_sticky: assert property (p_uv_sticky) // R8
        else $error("under-voltage event lost");
    property p_reset_power;
        @(posedge pclk) disable iff (!presetn)
        ce && armed_q && !stop_act && reset_contact
            |=> motor_power_en;
    endproperty
    a_reset_power: assert property (p_reset_power) // R1
        else $error("reset contact did not enable power");
    property p_power_free;
        @(posedge pclk) disable iff (!presetn)
        ce && !stop_act && !need_reset
            |=> motor_power_en;
    endproperty
    a_power_free: assert property (p_power_free) // R1
        else $error("power held off with no reset needed");
    // clock enable low must hold the power state
    property p_freeze;
        @(posedge pclk) disable iff (!presetn)
        !ce
            |=> $stable(motor_power_en);
    endproperty
    a_freeze: assert property (p_freeze) // R10
        else $error("power moved while clock enable low");
endmodule

// ### estop_brake_supervisor_test.sv
// estop_brake_supervisor_test: self-checking bench for esbs_top.
// assumes short blink phase (4 cycles) and the panel model.
module estop_brake_supervisor_test import esbs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        p_int, p_ext, p_press, lmv, llv, rgn, irq;
    logic [1:0]  p_brk, brk_req;
    logic        int_l, ext_l, rst_c, b1o, b2o, pwr, slo, rly;
    logic [2:0]  sn;
    logic        ce;
    esbs_lamp_t  lamp;
    int          failures = 0, checks = 0, cyc = 0;

    esbs_top #(.PHASE_CYC(4)) dut (.pclk, .presetn, .ce, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .internal_stop_loop(int_l), .external_stop_loop(ext_l),
        .reset_contact(rst_c), .low_motor_volt(lmv), .low_logic_volt(llv),
        .regen_locked(rgn), .brake_one_request(brk_req[0]),
        .brake_two_request(brk_req[1]), .brake_one_output(b1o),
        .brake_two_output(b2o), .motor_power_en(pwr),
        .stop_logic_output(slo), .relay_closed(rly), .lamp, .irq);
    esbs_panel panel (.pclk, .presetn, .want_int(p_int), .want_ext(p_ext),
        .press(p_press), .want_brk(p_brk), .internal_stop_loop(int_l),
        .external_stop_loop(ext_l), .reset_contact(rst_c), .brk_req);

    // free-running clock, 8 ns
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // hang guard: whole run needs well under this
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            summarize();
        end
    end

    task automatic summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // values read at an edge are the settled ones from before it
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer; no wait count assumed, timeout bounds it
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [11:0] a,
                       input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd & m);
    endtask
    // which lamp colours appear: bit0 off, bit1 green, bit2 red
    task automatic scan(input int n);
        sn = 3'b000;
        repeat (n) begin
            @(posedge pclk);
            sn[lamp] = 1'b1;
        end
    endtask

    task automatic t_reset;
        rdc("cfg reset", ESBS_OFF_CFG, 32'hff, 32'h70);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("ready", 32'h1, {31'h0, pready});
        wr(12'h020, 32'hff);
        rdc("cfg kept", ESBS_OFF_CFG, 32'hff, 32'h70);
        chk("power up", 32'h1, {31'h0, pwr});
        scan(16);
        chk("lamp ok", 32'h2, {29'h0, sn});
    endtask
    task automatic t_stop;
        p_int <= 1'b0;
        tick(4);
        chk("stop power", 32'h0, {31'h0, pwr});
        chk("relay free", 32'h1, {31'h0, rly});
        scan(16);
        chk("lamp open", 32'h6, {29'h0, sn});
        wr(ESBS_OFF_CFG, 32'h78);
        tick(3);
        chk("relay open", 32'h0, {31'h0, rly});
        wr(ESBS_OFF_CFG, 32'h68);
        tick(3);
        chk("int ignored", 32'h1, {31'h0, pwr});
        chk("relay shut", 32'h1, {31'h0, rly});
        p_int <= 1'b1;
        p_ext <= 1'b0;
        tick(4);
        chk("ext stop", 32'h0, {31'h0, pwr});
        wr(ESBS_OFF_CFG, 32'h58);
        tick(3);
        chk("ext ignored", 32'h1, {31'h0, pwr});
        p_ext <= 1'b1;
        wr(ESBS_OFF_CFG, 32'h70);
    endtask
    task automatic t_rearm;
        wr(ESBS_OFF_IRQ_CL, 32'h7);
        wr(ESBS_OFF_CFG, 32'h71);
        p_int <= 1'b0;
        tick(4);
        p_int <= 1'b1;
        tick(4);
        chk("wait reset", 32'h0, {31'h0, pwr});
        rdc("armed", ESBS_OFF_STATUS, 32'h41, 32'h40);
        rdc("irq events", ESBS_OFF_IRQ_ST, 32'h3, 32'h3);
        scan(16);
        chk("lamp wait", 32'h3, {29'h0, sn});
        p_press <= 1'b1;
        tick(1);
        p_press <= 1'b0;
        tick(6);
        chk("reset power", 32'h1, {31'h0, pwr});
        wr(ESBS_OFF_CFG, 32'h70);
    endtask
    task automatic t_logic;
        wr(ESBS_OFF_CFG, 32'h74);
        tick(3);
        chk("logic on", 32'h1, {31'h0, slo});
        p_int <= 1'b0;
        tick(4);
        chk("logic stop", 32'h0, {31'h0, slo});
        p_int <= 1'b1;
        wr(ESBS_OFF_CFG, 32'h70);
        tick(4);
        chk("logic false", 32'h0, {31'h0, slo});
    endtask
    task automatic t_brake;
        for (int p = 0; p < 2; p++) begin
            wr(ESBS_OFF_CFG, 32'h70 | (p << 1));
            for (int r = 0; r < 4; r++) begin
                p_brk <= 2'(r);
                tick(4);
                chk("brake one", 32'(r[0] == p[0]), {31'h0, b1o});
                chk("brake two", 32'(r[1] == p[0]), {31'h0, b2o});
            end
        end
        rdc("monitor", ESBS_OFF_MON, 32'hff, 32'hbf);
        wr(ESBS_OFF_CFG, 32'h70);
    endtask
    task automatic t_uv;
        wr(ESBS_OFF_IRQ_CL, 32'h7);
        wr(ESBS_OFF_IRQ_EN, 32'h4);
        rdc("irq enable", ESBS_OFF_IRQ_EN, 32'h7, 32'h4);
        lmv <= 1'b1;
        tick(4);
        chk("irq uv", 32'h1, {31'h0, irq});
        rdc("uv sticky", ESBS_OFF_IRQ_ST, 32'h4, 32'h4);
        scan(16);
        chk("lamp lowmp", 32'h4, {29'h0, sn});
        wr(ESBS_OFF_IRQ_EN, 32'h0);
        tick(2);
        chk("irq masked", 32'h0, {31'h0, irq});
        lmv <= 1'b0;
        wr(ESBS_OFF_IRQ_CL, 32'h4);
        rdc("uv cleared", ESBS_OFF_IRQ_ST, 32'h4, 32'h0);
        wr(ESBS_OFF_IRQ_EN, 32'h4);
        wr(ESBS_OFF_CFG, 32'h30);
        lmv <= 1'b1;
        llv <= 1'b1;
        tick(4);
        chk("uv off irq", 32'h0, {31'h0, irq});
        rdc("uv off st", ESBS_OFF_STATUS, 32'h18, 32'h0);
        lmv <= 1'b0;
        wr(ESBS_OFF_CFG, 32'h70);
        tick(4);
        rdc("low24 st", ESBS_OFF_STATUS, 32'h18, 32'h10);
        scan(16);
        chk("lamp low24", 32'h6, {29'h0, sn});
        llv <= 1'b0;
        rgn <= 1'b1;
        tick(4);
        rdc("regen st", ESBS_OFF_STATUS, 32'h20, 32'h20);
        scan(16);
        chk("lamp regen", 32'h6, {29'h0, sn});
        rgn <= 1'b0;
    endtask
    // clock enable low freezes the supervisor; the panel keeps moving
    task automatic t_freeze;
        ce    <= 1'b0;
        p_int <= 1'b0;
        tick(4);
        chk("frozen power", 32'h1, {31'h0, pwr});
        ce <= 1'b1;
        tick(3);
        chk("thawed stop", 32'h0, {31'h0, pwr});
        p_int <= 1'b1;
        tick(3);
        chk("power back", 32'h1, {31'h0, pwr});
    endtask

    // reset, then the scenarios in turn
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        {p_int, p_ext, p_press, p_brk} = 5'b11000;
        {lmv, llv, rgn} = 3'b000;
        ce = 1'b1;
        tick(3);
        presetn <= 1'b1;
        tick(3);
        t_reset();
        t_freeze();
        t_stop();
        t_rearm();
        t_logic();
        t_brake();
        t_uv();
        summarize();
    end
endmodule
